// *** rtl/bs2_mem_end.sv ***
// bs2_mem_end: memory end of the burst-of-two link, array included
// assumes: kTrue/kComp come from same-clock logic, one half cycle per clk;
// controls are valid in the clk cycle where kTrue first reads high
// orgWide is held steady while a write burst is in flight
`timescale 1ns/1ps
`include "bs2_consts.svh"

module bs2_mem_end (
   input  wire logic   clk,
   input  wire logic   rst_b,
   bs2_link.mem_end    link,
   input  wire logic   orgWide,
   output logic        readBusy,
   output logic        writeBusy
);
   // array word and address shapes
   localparam int AW = `BS2_AW;
   localparam int DW = `BS2_DW;

   logic [DW-1:0] mem [`BS2_DEPTH];

   // edge detection on the incoming clock pair
   logic kPrev;

   // command history across true edges
   logic lastRd;
   logic lastWr;
   logic prevIdle;

   // write sequencer state
   // address taken with the command, so beat 1 needs no address of its own
   logic          wrPend;
   logic [AW-1:0] wrAddr2;

   // read sequencer pipe
   logic [`BS2_PIPE_LEN-1:0] rdV;
   logic [AW-1:0]            rdA [`BS2_PIPE_LEN];

   // output registers
   logic [DW-1:0] q;
   logic          qOe_b;

   // lanes enabled by one beat's mask and the organisation
   function automatic logic [`BS2_LANES-1:0] lane_en(
      input logic [`BS2_LANES-1:0] mask_b,
      input logic                  wide
   );
      logic [`BS2_LANES-1:0] avail;
      avail = wide ? `BS2_LANES_WIDE : `BS2_LANES_NARROW;
      return ~mask_b & avail;
   endfunction : lane_en

   // merge new data into an old word lane by lane; lanes not enabled keep the old word
   function automatic logic [DW-1:0] merge(
      input logic [DW-1:0]         old,
      input logic [DW-1:0]         din,
      input logic [`BS2_LANES-1:0] en
   );
      logic [DW-1:0] res;
      res = old;
      for (int i = 0; i < `BS2_LANES; i++) begin
         if (en[i]) begin
            res[i*`BS2_LANE_W +: `BS2_LANE_W] = din[i*`BS2_LANE_W +: `BS2_LANE_W];
         end
      end
      return res;
   endfunction : merge

   // linear burst step; the address wraps at the top of the array
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
      return a + 1'b1;
   endfunction : next_addr

   // true edge is kTrue rising, complement edge is kTrue falling
   wire trueEdge = link.kTrue & ~kPrev;
   wire compEdge = ~link.kTrue & kPrev;

   // request decode at the true edge
   wire rdReq    = trueEdge & ~link.readSel_b;
   wire wrReq    = trueEdge & ~link.writeSel_b;
   wire idleNow  = link.readSel_b & link.writeSel_b;

   // a repeat of the same type on the next edge is dropped
   wire rdGo     = rdReq & ~lastRd;
   // after an idle slot a double request keeps only the read
   wire wrGo     = wrReq & ~lastWr & ~(prevIdle & rdReq);

   // beat lane enables, masks taken at each beat's own edge
   wire [`BS2_LANES-1:0] en0 = lane_en(link.laneMask_b, orgWide);
   wire [`BS2_LANES-1:0] en1 = lane_en(link.laneMask_b, orgWide);
   wire                  wrBeat1 = compEdge & wrPend;

   // second read beat address
   wire [AW-1:0] rdNext = next_addr(rdA[`BS2_RD_BEAT1]);

   // clock pair sampling; a halted pair simply yields no edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         kPrev <= 1'b0;
      end else begin
         kPrev <= link.kTrue;
      end
   end

   // history only moves on true edges, so a stopped clock freezes it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lastRd   <= 1'b0;
         lastWr   <= 1'b0;
         prevIdle <= 1'b1;
      end else if (trueEdge) begin
         lastRd   <= rdGo;
         lastWr   <= wrGo;
         prevIdle <= idleNow;
      end
   end

   // write sequencer: beat 0 at t, beat 1 owed at t+0.5
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPend  <= 1'b0;
         wrAddr2 <= '0;
      end else if (wrGo) begin
         wrPend  <= 1'b1;
         wrAddr2 <= next_addr(link.addr);
      end else if (wrBeat1) begin
         wrPend  <= 1'b0;
      end
   end

   // array writes; all masks high leaves the word untouched
   // storage has no reset; unwritten words read back unknown
   always_ff @(posedge clk) begin
      if (wrGo) begin
         mem[link.addr] <= merge(mem[link.addr], link.dIn, en0);
      end else if (wrBeat1) begin
         mem[wrAddr2] <= merge(mem[wrAddr2], link.dIn, en1);
      end
   end

   // read sequencer: address pipe, independent of the write side
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdV <= '0;
         for (int i = 0; i < `BS2_PIPE_LEN; i++) begin
            rdA[i] <= '0;
         end
      end else begin
         rdV    <= {rdV[`BS2_PIPE_LEN-2:0], rdGo};
         rdA[0] <= link.addr;
         for (int i = 1; i < `BS2_PIPE_LEN; i++) begin
            rdA[i] <= rdA[i-1];
         end
      end
   end

   // beats read the array late, so a write in flight is seen
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q     <= '0;
         qOe_b <= 1'b1;
      end else if (rdV[`BS2_RD_BEAT0]) begin
         q     <= mem[rdA[`BS2_RD_BEAT0]];
         qOe_b <= 1'b0;
      end else if (rdV[`BS2_RD_BEAT1]) begin
         q     <= mem[rdNext];
         qOe_b <= 1'b0;
      end else begin
         qOe_b <= 1'b1;
      end
   end

   // in-flight decode; a dropped request never shows as busy
   wire rdInFlight = rdGo | (|rdV[`BS2_PIPE_LEN-2:0]);
   wire wrInFlight = wrGo | (wrPend & ~wrBeat1);

   // busy flags for the user side
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         readBusy  <= 1'b0;
         writeBusy <= 1'b0;
      end else begin
         readBusy  <= rdInFlight;
         writeBusy <= wrInFlight;
      end
   end

   // pins straight from the output registers
   assign link.q     = q;
   assign link.qOe_b = qOe_b;
endmodule : bs2_mem_end

// *** rtl/bs2_consts.svh ***
// bs2_consts.svh: sizes and timing counts of the burst-of-two memory link
// assumes: one system clock; one memory cycle spans two system clocks
`ifndef BS2_CONSTS_SVH
`define BS2_CONSTS_SVH
`define BS2_CLK_NS      25
`define BS2_DW          36
`define BS2_AW          6
`define BS2_DEPTH       64
`define BS2_LANES       4
`define BS2_LANE_W      9
`define BS2_LANES_WIDE  4'hf
`define BS2_LANES_NARROW 4'h3
`define BS2_FIFO_DEPTH  32
`define BS2_FIFO_AW     5
// read pipe stage that launches beat 0 (t+2.5) and beat 1 (t+3.0)
`define BS2_RD_BEAT0    3
`define BS2_RD_BEAT1    4
`define BS2_PIPE_LEN    5
// half cycles of quiet needed after the last command before a clock stop
`define BS2_DRAIN_HALF  8
`endif

// *** rtl/bs2_pkg.sv ***
// bs2_pkg: types used by the controller end
// assumes: bs2_consts.svh on the include path
`include "bs2_consts.svh"
package bs2_pkg;
   typedef enum logic [0:0] {
      BS2_K_RUN  = 1'b0,
      BS2_K_STOP = 1'b1
   } bs2_kstate_t;
   typedef struct packed {
      logic                    wr;
      logic [`BS2_AW-1:0]      addr;
      logic [`BS2_DW-1:0]      d0;
      logic [`BS2_DW-1:0]      d1;
      logic [`BS2_LANES-1:0]   m0_b;
      logic [`BS2_LANES-1:0]   m1_b;
   } bs2_cmd_t;
endpackage : bs2_pkg

// *** rtl/bs2_link.sv ***
// bs2_link: pins between controller end and memory end
// assumes: both ends on the same clk; q is always driven but is valid only while qOe_b is low
`timescale 1ns/1ps
`include "bs2_consts.svh"
interface bs2_link;
   logic                  kTrue;
   logic                  kComp;
   logic                  readSel_b;
   logic                  writeSel_b;
   logic [`BS2_AW-1:0]    addr;
   logic [`BS2_DW-1:0]    dIn;
   logic [`BS2_LANES-1:0] laneMask_b;
   logic [`BS2_DW-1:0]    q;
   logic                  qOe_b;
   modport mem_end (input kTrue, kComp, readSel_b, writeSel_b, addr, dIn, laneMask_b,
                    output q, qOe_b);
   modport ctl_end (output kTrue, kComp, readSel_b, writeSel_b, addr, dIn, laneMask_b,
                    input q, qOe_b);
endinterface : bs2_link

// *** rtl/bs2_fifo.sv ***
// bs2_fifo: command buffer with valid/ready on both sides
// assumes: single clock; pop and push in one cycle are allowed
`timescale 1ns/1ps
module bs2_fifo #(
   parameter int W  = 8,
   parameter int D  = 32,
   parameter int AW = 5
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   logic [W-1:0]  store [D];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0]   count;
   wire           push = inValid & inReady;
   wire           pop  = outValid & outReady;

   // flags straight from the occupancy count
   assign inReady  = (count != (AW+1)'(D));
   assign outValid = (count != '0);
   assign outData  = store[rdPtr];

   // storage carries no reset; only pointers matter
   always_ff @(posedge clk) begin
      if (push) begin
         store[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) wrPtr <= wrPtr + 1'b1;
         if (pop) rdPtr <= rdPtr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bs2_fifo

// *** rtl/bs2_ctl_end.sv ***
// bs2_ctl_end: controller end; buffers commands and drives the clock pair
// assumes: memory end on the same clk; one half memory cycle per clk
`timescale 1ns/1ps
`include "bs2_consts.svh"
module bs2_ctl_end (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   bs2_link.ctl_end                   link,
   input  wire logic                  cmdValid,
   output logic                       cmdReady,
   input  wire logic                  cmdWrite,
   input  wire logic [`BS2_AW-1:0]    cmdAddr,
   input  wire logic [`BS2_DW-1:0]    cmdData0,
   input  wire logic [`BS2_DW-1:0]    cmdData1,
   input  wire logic [`BS2_LANES-1:0] cmdMask0_b,
   input  wire logic [`BS2_LANES-1:0] cmdMask1_b,
   input  wire logic                  stopReq,
   output logic                       clkStopped,
   output logic                       rdValid,
   output logic [`BS2_DW-1:0]         rdData
);
   localparam int CW = $bits(bs2_pkg::bs2_cmd_t);

   bs2_pkg::bs2_kstate_t  state;
   bs2_pkg::bs2_cmd_t     inCmd;
   bs2_pkg::bs2_cmd_t     head;
   logic                  headValid;
   logic                  kTrue;
   logic                  lastWasRd;
   logic                  lastWasWr;
   logic [`BS2_DW-1:0]    hold1;
   logic [`BS2_LANES-1:0] holdM1_b;
   logic [3:0]            drain;
   logic                  fifoReady;

   assign inCmd = '{wr: cmdWrite, addr: cmdAddr, d0: cmdData0, d1: cmdData1,
                    m0_b: cmdMask0_b, m1_b: cmdMask1_b};

   // stop only on the low phase, after every burst has drained
   wire running  = (state == bs2_pkg::BS2_K_RUN);
   wire stopNow  = running & stopReq & (drain == 4'h0) & ~kTrue;
   wire toTrue   = running & ~stopNow & ~kTrue;
   // never repeat a type on the next edge; a repeat waits out one idle edge
   wire typeOk   = head.wr ? ~lastWasWr : ~lastWasRd;
   wire issue    = toTrue & headValid & typeOk;

   // commands wait here; a stopped clock backs the source up
   bs2_fifo #(.W(CW), .D(`BS2_FIFO_DEPTH), .AW(`BS2_FIFO_AW)) cmdQ (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (cmdValid),
      .inReady  (fifoReady),
      .inData   (inCmd),
      .outValid (headValid),
      .outReady (issue),
      .outData  (head)
   );
   assign cmdReady = fifoReady;

   // clock pair and run state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= bs2_pkg::BS2_K_RUN;
         kTrue <= 1'b0;
      end else begin
         case (state)
            bs2_pkg::BS2_K_RUN: begin
               if (stopNow) state <= bs2_pkg::BS2_K_STOP;
               else kTrue <= ~kTrue;
            end
            bs2_pkg::BS2_K_STOP: begin
               if (!stopReq) state <= bs2_pkg::BS2_K_RUN;
            end
            default: state <= bs2_pkg::BS2_K_RUN;
         endcase
      end
   end

   // controls at the true edge, second write beat at the complement edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link.readSel_b  <= 1'b1;
         link.writeSel_b <= 1'b1;
         link.addr       <= '0;
         link.dIn        <= '0;
         link.laneMask_b <= 4'hf;
         lastWasRd       <= 1'b0;
         lastWasWr       <= 1'b0;
         hold1           <= '0;
         holdM1_b        <= 4'hf;
      end else if (toTrue) begin
         link.readSel_b  <= ~(issue & ~head.wr);
         link.writeSel_b <= ~(issue & head.wr);
         link.addr       <= head.addr;
         link.dIn        <= head.d0;
         link.laneMask_b <= issue ? head.m0_b : 4'hf;
         lastWasRd       <= issue & ~head.wr;
         lastWasWr       <= issue & head.wr;
         hold1           <= head.d1;
         holdM1_b        <= (issue & head.wr) ? head.m1_b : 4'hf;
      end else if (running & kTrue) begin
         link.dIn        <= hold1;
         link.laneMask_b <= holdM1_b;
      end
   end

   // quiet count guarding the clock stop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drain <= 4'h0;
      end else if (issue) begin
         drain <= 4'(`BS2_DRAIN_HALF);
      end else if (drain != 4'h0) begin
         drain <= drain - 4'h1;
      end
   end

   // read beats captured whenever the memory drives
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdValid    <= 1'b0;
         rdData     <= '0;
         clkStopped <= 1'b0;
      end else begin
         rdValid    <= ~link.qOe_b;
         rdData     <= link.qOe_b ? rdData : link.q;
         clkStopped <= stopNow | (~running & stopReq);
      end
   end

   assign link.kTrue = kTrue;
   assign link.kComp = ~kTrue;
endmodule : bs2_ctl_end

// *** tb/bs2_link_chk.sv ***
// bs2_link_chk: timing checks on the link between the two design ends
// assumes: one clk; link signals settle between its rising edges
`timescale 1ns/1ps
`include "bs2_consts.svh"
module bs2_link_chk (
   input wire logic               clk,
   input wire logic               rst_b,
   input wire logic               kTrue,
   input wire logic               kComp,
   input wire logic               readSel_b,
   input wire logic               writeSel_b,
   input wire logic [`BS2_AW-1:0] addr,
   input wire logic               qOe_b
);
   logic       kPrev;
   logic [3:0] quiet;
   // a true edge is the first cycle of kTrue high
   wire        edgeT      = kTrue & ~kPrev;
   wire        rdEdge     = edgeT & ~readSel_b;
   wire        wrEdge     = edgeT & ~writeSel_b;
   wire  [3:0] next_quiet = (rdEdge | wrEdge) ? 4'h0 : (quiet == 4'hf) ? quiet : quiet + 4'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // quiet saturates so a long stop stays legal
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         kPrev <= 1'b0;
         quiet <= 4'hf;
      end else begin
         kPrev <= kTrue;
         quiet <= next_quiet;
      end
   end
   sequence read_beats;
      !qOe_b ##1 !qOe_b ##1 qOe_b;
   endsequence
   a_comp_inverse: assert property (kComp == ~kTrue)
      else $error("complement clock not inverse of true clock");
   a_read_latency: assert property (rdEdge |-> ##5 read_beats)
      else $error("read beats not at the fixed latency");
   a_beat_source: assert property ($fell(qOe_b) |-> $past(rdEdge, 5))
      else $error("output driven without a read");
   a_two_beats: assert property ($fell(qOe_b) |-> read_beats)
      else $error("read burst not two beats");
   a_read_spacing: assert property (rdEdge |=> ##1 !rdEdge)
      else $error("reads on adjacent true edges");
   a_write_spacing: assert property (wrEdge |=> ##1 !wrEdge)
      else $error("writes on adjacent true edges");
   a_single_select: assert property (edgeT |-> (readSel_b | writeSel_b))
      else $error("both selects low from controller");
   a_stop_drained: assert property ($stable(kTrue) |-> quiet >= 4'h6)
      else $error("clock stopped with a burst pending");
   a_stop_hold: assert property ($stable(kTrue) |-> $stable(readSel_b) && $stable(addr))
      else $error("controls moved while clock stopped");
endmodule : bs2_link_chk

// *** tb/tb_burst2_sram_command_port.sv ***
// tb_burst2_sram_command_port: both ends back to back, plus a lone memory end
// assumes: rtl compiled first; bs2_consts.svh on the include path
`timescale 1ns/1ps
`include "bs2_consts.svh"
module tb_burst2_sram_command_port;
   typedef logic [`BS2_DW-1:0] bs2_w_t;
   logic                  clk, rst_b, orgWide, cmdValid, cmdReady, cmdWrite;
   logic                  stopReq, clkStopped, rdValid, rdBusy, wrBusy;
   logic [`BS2_AW-1:0]    cmdAddr;
   logic [`BS2_LANES-1:0] cmdMask0_b, cmdMask1_b;
   bs2_w_t                cmdData0, cmdData1, rdData, shadow [64], da, db;
   bs2_w_t                exp1 [$], exp2 [$];
   int                    failures, checked, cycles;

   bs2_link i_bs2_link ();
   bs2_link i_bs2_link_b ();
   bs2_ctl_end i_bs2_ctl_end (.clk(clk), .rst_b(rst_b), .link(i_bs2_link.ctl_end),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
      .cmdData0(cmdData0), .cmdData1(cmdData1), .cmdMask0_b(cmdMask0_b),
      .cmdMask1_b(cmdMask1_b), .stopReq(stopReq), .clkStopped(clkStopped),
      .rdValid(rdValid), .rdData(rdData));
   bs2_mem_end i_bs2_mem_end (.clk(clk), .rst_b(rst_b), .link(i_bs2_link.mem_end),
      .orgWide(orgWide), .readBusy(rdBusy), .writeBusy(wrBusy));
   // second memory end, driven by the bench to break controller rules
   bs2_mem_end i_bs2_mem_end_b (.clk(clk), .rst_b(rst_b), .link(i_bs2_link_b.mem_end),
      .orgWide(1'b1), .readBusy(), .writeBusy());
   bs2_link_chk i_bs2_link_chk (.clk(clk), .rst_b(rst_b), .kTrue(i_bs2_link.kTrue),
      .kComp(i_bs2_link.kComp), .readSel_b(i_bs2_link.readSel_b),
      .writeSel_b(i_bs2_link.writeSel_b), .addr(i_bs2_link.addr), .qOe_b(i_bs2_link.qOe_b));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input bs2_w_t got, input bs2_w_t want);
      checked++;
      if (got !== want) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk

   // shadow copy of one beat; narrow mode never touches lanes 2 and 3
   function automatic bs2_w_t merge(input bs2_w_t old, input bs2_w_t d, input logic [3:0] m_b);
      bs2_w_t r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (!m_b[i] && (orgWide || i < 2)) r[9*i +: 9] = d[9*i +: 9];
      return r;
   endfunction : merge

   // called at a rising edge; returns at the edge that took the command
   task automatic push(input logic w, input logic [5:0] a, input logic [3:0] m0, m1);
      bs2_w_t d0, d1;
      logic   r;
      d0 = bs2_w_t'({$urandom, $urandom});
      d1 = bs2_w_t'({$urandom, $urandom});
      if (w) begin
         shadow[a] = merge(shadow[a], d0, m0);
         shadow[a + 6'h1] = merge(shadow[a + 6'h1], d1, m1);
      end else begin
         exp1.push_back(shadow[a]);
         exp1.push_back(shadow[a + 6'h1]);
      end
      {cmdValid, cmdWrite, cmdAddr, cmdMask0_b, cmdMask1_b} <= {1'b1, w, a, m0, m1};
      {cmdData0, cmdData1} <= {d0, d1};
      r = 1'b0;
      while (!r) begin
         @(negedge clk) r = cmdReady;
         @(posedge clk);
      end
   endtask : push

   task automatic drv2(input logic k, r, w, input logic [5:0] a, input bs2_w_t d);
      i_bs2_link_b.kTrue <= k;
      i_bs2_link_b.kComp <= ~k;
      {i_bs2_link_b.readSel_b, i_bs2_link_b.writeSel_b, i_bs2_link_b.addr} <= {r, w, a};
      {i_bs2_link_b.dIn, i_bs2_link_b.laneMask_b} <= {d, 4'h0};
   endtask : drv2

   // one memory cycle on the lone link: true edge, then complement edge
   task automatic ms(input logic r, w, input logic [5:0] a, input bs2_w_t d);
      @(posedge clk) drv2(1'b1, r, w, a, d);
      @(posedge clk) drv2(1'b0, 1'b1, 1'b1, a, d);
   endtask : ms

   // drain and wait out the quiet time the clock stop needs
   task automatic settle(input string name);
      int still = 0;
      cmdValid <= 1'b0;
      for (int i = 0; i < 900 && still < 8; i++) begin
         @(posedge clk);
         still = (exp1.size() + exp2.size() > 0 || rdBusy || wrBusy) ? 0 : still + 1;
      end
      chk(bs2_w_t'(exp1.size() + exp2.size()), '0);
      chk(bs2_w_t'({rdBusy, wrBusy}), '0);
      $display("test %s done", name);
   endtask : settle

   // read beats on both links matched in order against what the pushes and the lone-link test promised
   always @(posedge clk) begin
      if (rst_b === 1'b1 && rdValid !== 1'b0) begin
         if (exp1.size() > 0) chk(rdData, exp1.pop_front());
         else chk(bs2_w_t'(rdValid), '0);
      end
      if (rst_b === 1'b1 && i_bs2_link_b.qOe_b !== 1'b1) begin
         if (exp2.size() > 0) chk(i_bs2_link_b.q, exp2.pop_front());
         else chk(bs2_w_t'(i_bs2_link_b.qOe_b), bs2_w_t'(1));
      end
   end

   // ceiling far above the ~700 clk the tests take
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures++;
         complete_run();
      end
   end

   initial begin
      {rst_b, orgWide, cmdValid, cmdWrite, stopReq, cmdAddr} = {4'h4, 1'b0, 6'h0};
      {cmdData0, cmdData1, cmdMask0_b, cmdMask1_b} = '1;
      {failures, checked, cycles} = '0;
      drv2(1'b0, 1'b1, 1'b1, 6'h0, '0);
      void'($urandom(32'h601b));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // fill the buffer with the clock held stopped
      stopReq <= 1'b1;
      for (int i = 0; i < 40 && clkStopped !== 1'b1; i++) @(posedge clk);
      for (int i = 0; i < 32; i++) push(1'b1, 6'(2*i), 4'h0, 4'h0);
      @(negedge clk) chk(bs2_w_t'(cmdReady), '0);
      chk(bs2_w_t'(clkStopped), bs2_w_t'(1));
      @(posedge clk) stopReq <= 1'b0;
      settle("fill");
      for (int i = 0; i < 32; i++) push(1'b0, 6'(2*i), 4'h0, 4'h0);
      push(1'b0, 6'h3f, 4'h0, 4'h0);
      settle("readback");
      for (int o = 1; o >= 0; o--) begin
         orgWide <= o[0];
         @(posedge clk);
         for (int i = 0; i < 32; i++) begin
            push(1'b1, 6'(2*i), 4'($urandom), 4'($urandom));
            push(1'b0, 6'(2*i), 4'h0, 4'h0);
         end
         settle("lanes");
      end
      da = bs2_w_t'({$urandom, $urandom});
      db = ~da;
      ms(1'b1, 1'b0, 6'h0, da);
      ms(1'b1, 1'b1, 6'h0, '0);
      for (int i = 0; i < 8; i++) exp2.push_back((i == 4 || i == 5) ? db : da);
      ms(1'b0, 1'b0, 6'h0, db);
      repeat (3) ms(1'b1, 1'b1, 6'h0, '0);
      ms(1'b0, 1'b1, 6'h0, '0);
      ms(1'b0, 1'b1, 6'h0, '0);
      repeat (3) ms(1'b1, 1'b1, 6'h0, '0);
      ms(1'b1, 1'b0, 6'h2, db);
      ms(1'b1, 1'b0, 6'h2, da);
      ms(1'b0, 1'b1, 6'h2, '0);
      // both low after a read slot: read dropped by spacing, write kept
      ms(1'b0, 1'b0, 6'h4, da);
      ms(1'b1, 1'b1, 6'h0, '0);
      ms(1'b0, 1'b1, 6'h4, '0);
      repeat (4) ms(1'b1, 1'b1, 6'h0, '0);
      settle("refusals");
      complete_run();
   end
endmodule : tb_burst2_sram_command_port
